// File: hdl/backplane_pci_arbiter.sv
// Notes on behaviour
// RULE_01 - serve seven card masters plus local bridge
// RULE_02 - rotate priority; last winner ranks lowest
// RULE_03 - pending request granted within one slot clock
// RULE_04 - no FRAME within sixteen clocks: drop grant
// RULE_05 - park on last master until new request
// RULE_06 - after reset park on the local bridge
// RULE_07 - drive slot clocks while owning the bus
// RULE_08 - one grant at most, changed on clock edge
`timescale 1ns/100ps
`include "arb_consts.svh"
module backplane_pci_arbiter
  import arb_pkg::*;
#(
  parameter int NUM_CARDS = `ARB_NUM_CARDS,
  parameter int NUM_MASTERS = NUM_CARDS + 1,
  parameter int IDX_W = $clog2(NUM_MASTERS)
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // bus requests, bit 0 is the local bridge, active low
  input wire logic [NUM_MASTERS-1:0] REQ_N,
  // bus activity, active low
  input wire logic FRAME_N,
  input wire logic IRDY_N,
  // high while this board owns the backplane bus
  input wire logic BUS_OWNER,
  // grants, active low
  output logic [NUM_MASTERS-1:0] GNT_N,
  // clocks to the card slots
  output logic [NUM_CARDS-1:0] SLOT_CLK
);

  // ==========================================================
  // declarations
  localparam logic [7:0] DIV = `ARB_PCI_DIV_CYCLES;
  localparam logic [7:0] HIGH = `ARB_PCI_HIGH_CYCLES;
  localparam logic [IDX_W-1:0] PARK_IDX = IDX_W'(`ARB_PARK_RESET_IDX);
  localparam logic [NUM_MASTERS-1:0] PARK_GNT_N = ~(NUM_MASTERS'(1) << PARK_IDX);

  logic [NUM_MASTERS-1:0] req_n_meta_reg;
  logic [NUM_MASTERS-1:0] req_n_sync_reg;
  logic [1:0] bus_n_meta_reg;
  logic [1:0] bus_n_sync_reg;
  logic owner_meta_reg;
  logic owner_sync_reg;
  logic [7:0] div_cnt_reg;
  logic pci_tick;
  logic [NUM_MASTERS-1:0] req;
  logic bus_busy;
  arb_state_t state_reg;
  arb_state_t state_next;
  logic [IDX_W-1:0] master_reg;
  logic [IDX_W-1:0] master_next;
  logic gnt_on_reg;
  logic gnt_on_next;
  logic [4:0] wait_cnt_reg;
  logic [4:0] wait_cnt_next;
  logic [NUM_MASTERS-1:0] gnt_n_reg;
  logic [NUM_CARDS-1:0] slot_clk_reg;
  logic [NUM_MASTERS-1:0] pick_req;
  logic [IDX_W-1:0] pick_idx;
  logic pick_any;
  logic after_reset_reg;

  // ==========================================================
  // pin synchronisers
  // two stages on every pin before any logic reads it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      req_n_meta_reg <= '1;
      req_n_sync_reg <= '1;
      bus_n_meta_reg <= 2'h3;
      bus_n_sync_reg <= 2'h3;
      owner_meta_reg <= 1'b0;
      owner_sync_reg <= 1'b0;
    end else begin
      req_n_meta_reg <= REQ_N;
      req_n_sync_reg <= req_n_meta_reg;
      bus_n_meta_reg <= {FRAME_N, IRDY_N};
      bus_n_sync_reg <= bus_n_meta_reg;
      owner_meta_reg <= BUS_OWNER;
      owner_sync_reg <= owner_meta_reg;
    end
  end

  assign req = ~req_n_sync_reg; // see RULE_01
  assign bus_busy = ~&bus_n_sync_reg;

  // ==========================================================
  // slot clock divider
  // one tick per slot clock period, just before its rising edge
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_cnt_reg <= 8'h00;
    end else if (pci_tick) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  assign pci_tick = (div_cnt_reg == DIV - 8'h01);

  // slot clocks run only while the bus is ours
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      slot_clk_reg <= '0;
    end else if (owner_sync_reg) begin
      slot_clk_reg <= {NUM_CARDS{div_cnt_reg < HIGH}}; // see RULE_07
    end else begin
      slot_clk_reg <= '0;
    end
  end

  // ==========================================================
  // rotating pick
  // the holder is masked out so a parked grant can move on
  assign pick_req = (state_reg == ST_WAIT) ? (req & ~(NUM_MASTERS'(1) << master_reg)) : req;

  rr_pick #(
    .N(NUM_MASTERS),
    .W(IDX_W)
  ) u_pick (
    .req(pick_req),
    .last(master_reg),
    .win(pick_idx), // see RULE_02
    .any(pick_any)
  );

  // ==========================================================
  // arbitration sequencing
  always_comb begin
    state_next = state_reg;
    master_next = master_reg;
    gnt_on_next = gnt_on_reg;
    wait_cnt_next = wait_cnt_reg;
    case (state_reg)
      ST_WAIT: begin
        if (bus_busy) begin
          state_next = ST_XFER;
          wait_cnt_next = 5'h00;
        end else if (req[master_reg]) begin
          if (wait_cnt_reg == `ARB_GRANT_TIMEOUT_CLKS - 5'h01) begin
            state_next = ST_DROP; // see RULE_04
            gnt_on_next = 1'b0;
            wait_cnt_next = 5'h00;
          end else begin
            wait_cnt_next = wait_cnt_reg + 5'h01;
          end
        end else if (pick_any) begin
          master_next = pick_idx; // see RULE_03
          gnt_on_next = 1'b1;
          wait_cnt_next = 5'h00;
        end else begin
          wait_cnt_next = 5'h00; // see RULE_05
        end
      end
      ST_XFER: begin
        if (!bus_busy) begin
          state_next = ST_ARB;
        end
      end
      ST_ARB: begin
        state_next = ST_WAIT;
        gnt_on_next = 1'b1; // see RULE_05
        wait_cnt_next = 5'h00;
        if (pick_any) begin
          master_next = pick_idx; // see RULE_03
        end
      end
      ST_DROP: begin
        state_next = ST_ARB;
      end
      default: begin
        state_next = ST_ARB;
      end
    endcase
  end

  // state moves only on slot clock ticks
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ST_WAIT;
      master_reg <= PARK_IDX; // see RULE_06
      gnt_on_reg <= 1'b1;
      wait_cnt_reg <= 5'h00;
    end else if (pci_tick) begin
      state_reg <= state_next;
      master_reg <= master_next;
      gnt_on_reg <= gnt_on_next;
      wait_cnt_reg <= wait_cnt_next;
    end
  end

  // grant register, at most one bit low, updated on the tick only
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      gnt_n_reg <= PARK_GNT_N; // see RULE_06
    end else if (pci_tick) begin
      gnt_n_reg <= ~({NUM_MASTERS{gnt_on_next}} & (NUM_MASTERS'(1) << master_next)); // see RULE_08
    end
  end

  // flags the first cycle after reset for checking
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      after_reset_reg <= 1'b1;
    end else begin
      after_reset_reg <= 1'b0;
    end
  end

  assign GNT_N = gnt_n_reg;
  assign SLOT_CLK = slot_clk_reg;

  // ==========================================================
  // checks
  sequence s_tick_gap;
    !pci_tick [*5] ##1 pci_tick;
  endsequence

  sequence s_timeout_tick;
    pci_tick && state_reg == ST_WAIT && !bus_busy && req[master_reg]
      && wait_cnt_reg == `ARB_GRANT_TIMEOUT_CLKS - 5'h01;
  endsequence

  property p_one_grant;
    @(posedge CLK) disable iff (!RSTN) $onehot0(~gnt_n_reg);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("two grants at once"); // see RULE_08

  property p_grant_on_tick;
    @(posedge CLK) disable iff (!RSTN) !$stable(gnt_n_reg) |-> $past(pci_tick);
  endproperty
  a_grant_on_tick: assert property (p_grant_on_tick) else $error("grant moved off tick"); // see RULE_08

  property p_reset_park;
    @(posedge CLK) disable iff (!RSTN)
      after_reset_reg |-> gnt_n_reg == PARK_GNT_N && state_reg == ST_WAIT;
  endproperty
  a_reset_park: assert property (p_reset_park) else $error("not parked on bridge"); // see RULE_06

  property p_timeout_drop;
    @(posedge CLK) disable iff (!RSTN)
      s_timeout_tick |=> &gnt_n_reg ##1 (&gnt_n_reg) [*5];
  endproperty
  a_timeout_drop: assert property (p_timeout_drop) else $error("late grant not dropped"); // see RULE_04

  property p_no_early_drop;
    @(posedge CLK) disable iff (!RSTN)
      pci_tick && state_reg == ST_WAIT && !bus_busy && req[master_reg]
        && wait_cnt_reg < `ARB_GRANT_TIMEOUT_CLKS - 5'h01 |=> $stable(gnt_n_reg) && !(&gnt_n_reg);
  endproperty
  a_no_early_drop: assert property (p_no_early_drop) else $error("grant dropped early"); // see RULE_04

  property p_park_hold;
    @(posedge CLK) disable iff (!RSTN)
      pci_tick && state_reg == ST_WAIT && req == '0 && !bus_busy |=> $stable(gnt_n_reg);
  endproperty
  a_park_hold: assert property (p_park_hold) else $error("parked grant lost"); // see RULE_05

  property p_rotate;
    @(posedge CLK) disable iff (!RSTN)
      pci_tick && state_reg == ST_ARB && (req & ~(NUM_MASTERS'(1) << master_reg)) != '0
        |=> gnt_n_reg[$past(master_reg)];
  endproperty
  a_rotate: assert property (p_rotate) else $error("last winner regranted"); // see RULE_02

  property p_grant_fast;
    @(posedge CLK) disable iff (!RSTN)
      pci_tick && state_reg == ST_ARB && req != '0 |=> ((~gnt_n_reg) & $past(req)) != '0;
  endproperty
  a_grant_fast: assert property (p_grant_fast) else $error("pending request not granted"); // see RULE_03

  property p_slot_off;
    @(posedge CLK) disable iff (!RSTN) !owner_sync_reg |=> slot_clk_reg == '0;
  endproperty
  a_slot_off: assert property (p_slot_off) else $error("slot clock while not owner"); // see RULE_07

  property p_slot_period;
    @(posedge CLK) disable iff (!RSTN) pci_tick |=> s_tick_gap;
  endproperty
  a_slot_period: assert property (p_slot_period) else $error("slot clock period wrong"); // see RULE_07

endmodule : backplane_pci_arbiter

// File: hdl/arb_consts.svh
`ifndef ARB_CONSTS_SVH
`define ARB_CONSTS_SVH

// system clock and the slot clock rate, in MHz as given
`define ARB_SYS_CLK_MHZ 8'd200
`define ARB_PCI_CLK_MHZ 8'd33
// system cycles per slot clock period and per high phase
`define ARB_PCI_DIV_CYCLES (`ARB_SYS_CLK_MHZ / `ARB_PCI_CLK_MHZ)
`define ARB_PCI_HIGH_CYCLES (`ARB_PCI_DIV_CYCLES / 8'd2)
// slot clocks a granted master has to start its cycle
`define ARB_GRANT_TIMEOUT_CLKS 5'd16
// master parked on after reset: the local bridge
`define ARB_PARK_RESET_IDX 0
// number of backplane peripheral cards served
`define ARB_NUM_CARDS 7

`endif

// File: hdl/arb_pkg.sv
package arb_pkg;

  // arbiter sequencing states
  typedef enum logic [1:0] {
    ST_ARB  = 2'b00,
    ST_WAIT = 2'b01,
    ST_XFER = 2'b10,
    ST_DROP = 2'b11
  } arb_state_t;

endpackage : arb_pkg

// File: hdl/rr_pick.sv
`timescale 1ns/100ps
module rr_pick
  import arb_pkg::*;
#(
  parameter int N = 8,
  parameter int W = $clog2(N)
) (
  // request vector and last winner
  input wire logic [N-1:0] req,
  input wire logic [W-1:0] last,
  // chosen requester
  output logic [W-1:0] win,
  output logic any
);

  // search starts just after the last winner, so it ranks lowest
  always_comb begin
    logic [W:0] idx;
    idx = '0;
    win = last;
    any = 1'b0;
    for (int k = 1; k <= N; k++) begin
      idx = (W+1)'((int'(last) + k) % N);
      if (!any && req[idx[W-1:0]]) begin
        win = idx[W-1:0];
        any = 1'b1;
      end
    end
  end

endmodule : rr_pick

// File: verification/card_masters.sv
`timescale 1ns/100ps
// ==========================================
// card masters on the far side of the arbiter
module card_masters (
  // clock and grants
  input wire logic clk,
  input wire logic [7:0] gnt_n,
  // bench control
  input wire logic [7:0] raise,
  input wire logic stall,
  input wire logic [4:0] lag,
  // bus side, idle lines pulled high
  output logic [7:0] req_n,
  output logic frame_n = 1'b1,
  output logic irdy_n = 1'b1,
  // end of a transfer
  output logic done = 1'b0,
  output logic [2:0] who = 3'h0
);
  logic [7:0] pend = 8'h00;
  logic [7:0] clr;
  int cnt = 0;
  int busy = 0;
  assign req_n = ~pend;
  assign clr = (busy == 1) ? (8'h01 << who) : 8'h00;
  // start a short transfer lag clocks after the grant; stall models a dead master
  always @(posedge clk) begin
    done <= 1'b0;
    pend <= (pend | raise) & ~clr;
    if (busy > 0) begin
      busy <= busy - 1;
      frame_n <= (busy > 2) ? 1'b0 : 1'b1;
      irdy_n <= (busy > 1) ? 1'b0 : 1'b1;
      done <= (busy == 1);
    end else if (!stall && (~gnt_n & pend) != 8'h00) begin
      if (cnt >= int'(lag)) begin
        for (int i = 0; i < 8; i++) if (!gnt_n[i]) who <= 3'(i);
        frame_n <= 1'b0;
        irdy_n <= 1'b0;
        busy <= 4;
        cnt <= 0;
      end else cnt <= cnt + 1;
    end else cnt <= 0;
  end
endmodule : card_masters

// File: verification/backplane_pci_arbiter_test.sv
`timescale 1ns/100ps
// ==========================================
// arbiter bench with a rotation model
module backplane_pci_arbiter_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic owner = 1'b0;
  logic stall = 1'b0;
  logic [7:0] raise = 8'h00;
  logic [4:0] lag = 5'h00;
  logic [7:0] req_n, gnt_n, m;
  logic frame_n, irdy_n, done, p;
  logic [6:0] slot_clk;
  logic [2:0] who;
  int fails = 0;
  int n_checks = 0;
  int seed = 32'h617c0726;
  int last = 0;
  int q[$];
  int k, t;
  backplane_pci_arbiter dut (.CLK(clk), .RSTN(rstn), .REQ_N(req_n), .FRAME_N(frame_n),
    .IRDY_N(irdy_n), .BUS_OWNER(owner), .GNT_N(gnt_n), .SLOT_CLK(slot_clk));
  card_masters cards (.clk(clk), .gnt_n(gnt_n), .raise(raise), .stall(stall), .lag(lag),
    .req_n(req_n), .frame_n(frame_n), .irdy_n(irdy_n), .done(done), .who(who));
  // clock, 5 ns period
  initial forever #2.5 clk = ~clk;
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // no more than one grant in any cycle
  always @(negedge clk) if (rstn) begin
    check((^gnt_n !== 1'bx) && $countones(~gnt_n) <= 1, "grants");
  end
  // each finished transfer against the predicted order
  // while reset is low the park goes back to the bridge
  always @(posedge clk) if (!rstn) begin
    last = 0;
  end else if (done) begin
    check(q.size() > 0 && who === 3'(q[0]), "order");
    if (q.size() > 0) last = q.pop_front();
  end
  // raise a set at once, predict rotation after the last winner
  task automatic batch(input logic [7:0] b);
    int i;
    i = last;
    repeat (8) begin
      i = (i + 1) % 8;
      if (b[i]) q.push_back(i);
    end
    lag <= 5'($random(seed));
    raise <= b;
    @(posedge clk);
    raise <= 8'h00;
    t = 0;
    while (gnt_n !== ~(8'h01 << q[0]) && t < 30) begin
      @(posedge clk);
      t++;
    end
    check(t <= 10, "latency");
    t = 0;
    while (q.size() > 0 && t < 900) begin
      @(posedge clk);
      t++;
    end
    check(q.size() == 0, "not served");
    repeat (15) @(posedge clk);
    check(gnt_n === ~(8'h01 << last), "park");
  endtask : batch
  // wait while a grant pattern holds, counting clocks
  task automatic hold(input logic [7:0] g);
    t = 0;
    while (gnt_n === g && t < 300) begin
      @(posedge clk);
      t++;
    end
  endtask : hold
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    check(gnt_n === 8'hfe, "reset park");
    batch(8'hfe);
    repeat (6) begin
      m = 8'($random(seed)) & ~(8'h01 << last);
      if (m == 8'h00) m = ~(8'h01 << last);
      batch(m);
    end
    // dead master loses its grant after 16 slot clocks
    k = (last == 5) ? 6 : 5;
    stall <= 1'b1;
    q.push_back(k);
    raise <= 8'h01 << k;
    @(posedge clk);
    raise <= 8'h00;
    hold(~(8'h01 << last));
    hold(~(8'h01 << k));
    check(t == 96, "timeout");
    hold(8'hff);
    check(t == 12 && gnt_n === ~(8'h01 << k), "regrant");
    stall <= 1'b0;
    repeat (40) @(posedge clk);
    check(q.size() == 0, "late transfer");
    // slot clocks only while owning the bus
    owner <= 1'b1;
    repeat (10) @(posedge clk);
    t = 0;
    k = 0;
    p = slot_clk[0];
    repeat (60) begin
      @(posedge clk);
      if (slot_clk[0] && !p) t++;
      if (slot_clk !== {7{slot_clk[0]}}) k++;
      p = slot_clk[0];
    end
    check(t == 10 && k == 0, "slot clock");
    owner <= 1'b0;
    repeat (6) @(posedge clk);
    k = 0;
    repeat (30) begin
      @(posedge clk);
      if (slot_clk !== 7'h00) k++;
    end
    check(k == 0, "slot clock off");
    // second reset returns the park to the bridge
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check(gnt_n === 8'hfe, "reset park");
    batch(8'h88);
    report_and_stop();
  end
  // watchdog
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule : backplane_pci_arbiter_test
